// ---- rtl/adcc_pkg.sv ----
// Package: register map, field positions, reset values and timing counts
package adcc_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses (APB, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] INPUT_SELECT_OFS   = 8'h00;
  localparam logic [7:0] CONTROL_STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_LOW_OFS     = 8'h08;
  localparam logic [7:0] RESULT_HIGH_OFS    = 8'h0C;
  localparam logic [7:0] SPECIAL_FUNC_OFS   = 8'h10;
  localparam logic [7:0] PROC_STATUS_OFS    = 8'h14;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] INPUT_SELECT_RST   = 8'h00;
  localparam logic [7:0] CONTROL_STATUS_RST = 8'h00;
  localparam logic [7:0] SPECIAL_FUNC_RST   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int REF_SEL_MSB    = 7;
  localparam int REF_SEL_LSB    = 6;
  localparam int LEFT_ALIGN_BIT = 5;
  localparam int CHAN_SEL_MSB   = 4;
  localparam int ENABLE_BIT     = 7;
  localparam int START_BIT      = 6;
  localparam int AUTO_TRIG_BIT  = 5;
  localparam int DONE_FLAG_BIT  = 4;
  localparam int IRQ_EN_BIT     = 3;
  localparam int PRESCALE_MSB   = 2;
  localparam int TRIG_SEL_MSB   = 7;
  localparam int TRIG_SEL_LSB   = 5;
  localparam int GLOBAL_IE_BIT  = 7;

  // ----------------------------------------------------------------------
  // Timing counts, in converter clock cycles, and the free-running trigger code
  // ----------------------------------------------------------------------
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
  localparam logic [2:0] TRIG_FREE_RUN      = 3'h0;

  // ----------------------------------------------------------------------
  // Conversion control states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONVERT
  } adcc_state_t;

endpackage

// ---- rtl/adcc_top.sv ----
// Converter control/status registers with APB slave and analog core interface
//
// Behaviour
// R1 - Bits 7:6 pick reference: 00 pin, 01 supply, 10 reserved, 11 internal
// R2 - Reference and channel writes during conversion apply only at completion
// R3 - Bit 5 set presents result left-adjusted, clear right-adjusted
// R4 - Alignment change alters presented result at once, even mid-conversion
// R5 - Channel codes 00000-00111 select single-ended inputs 0-7, no gain
// R6 - Codes 01000-01111 select differential pairs with 10x or 200x gain
// R7 - Codes 10000-10111 against input 1, 11000-11100 against input 2, 1x
// R8 - 11101 input 5 versus 2, 11110 bandgap, 11111 ground
// R9 - Enable bit powers converter; clearing it aborts a running conversion
// R10 - Software writes start once per single conversion, once for free run
// R11 - First conversion after enable takes 25 converter cycles, later 13
// R12 - Start bit reads one while converting; writing zero does nothing
// R13 - Auto trigger starts a conversion on each rising trigger edge
// R14 - Completion flag sets when conversion ends and result registers update
// R15 - Interrupt requested when flag, enable and global enable all set
// R16 - Flag clears on vector acknowledge or written one; zero leaves it
// R17 - Software avoids read-modify-write on control/status register
// R18 - Prescale codes 000-111 divide by 2,2,4,8,16,32,64,128
// R19 - Right: bits 9:8 in high 1:0; left: 9:2 high, 1:0 low 7:6
// R20 - After low byte read, result frozen until high byte read
// R21 - Trigger select 000 free-running; other codes pick flag sources
// R22 - Analog core stub latches selection at start, returns 10-bit result
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module adcc_top #(
  parameter int TRIG_SOURCES = 7
) (
  // APB clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Trigger flags from other peripherals (asynchronous)
  input  wire logic [TRIG_SOURCES-1:0] trigger_flags,
  // Interrupt handshake
  input  wire logic                    completion_irq_ack,
  output logic                         completion_irq,
  // Analog core control
  output logic                         converter_power,
  output logic [1:0]                   reference_select,
  output logic [4:0]                   channel_gain_select,
  output logic                         sample_hold,
  output logic                         converter_clock,
  // Analog core result
  input  wire logic [9:0]              analog_result
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]                  input_select_q;
  logic                        enable_q;
  logic                        auto_trig_q;
  logic                        done_flag_q;
  logic                        irq_en_q;
  logic [2:0]                  prescale_q;
  logic [2:0]                  trig_sel_q;
  logic                        global_ie_q;
  logic [1:0]                  ref_lat_q;
  logic [4:0]                  chan_lat_q;
  logic [9:0]                  result_q;
  logic                        low_read_q;
  logic                        first_q;
  logic [6:0]                  presc_cnt_q;
  logic                        conv_clk_q;
  logic [4:0]                  cycle_cnt_q;
  adcc_pkg::adcc_state_t       state_q;
  logic [TRIG_SOURCES-1:0]     trig_s1_q;
  logic [TRIG_SOURCES-1:0]     trig_s2_q;
  logic [TRIG_SOURCES-1:0]     trig_s3_q;
  logic [TRIG_SOURCES-1:0]     trig_stable_q;
  logic                        trig_prev_q;
  logic                        pready_q;
  logic [31:0]                 prdata_q;
  logic                        pslverr_q;
  logic                        irq_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire setup    = psel & ~penable;
  wire wr_en    = setup & pwrite;
  wire rd_en    = setup & ~pwrite;
  wire hit_mux  = (paddr == adcc_pkg::INPUT_SELECT_OFS);
  wire hit_csr  = (paddr == adcc_pkg::CONTROL_STATUS_OFS);
  wire hit_lo   = (paddr == adcc_pkg::RESULT_LOW_OFS);
  wire hit_hi   = (paddr == adcc_pkg::RESULT_HIGH_OFS);
  wire hit_sfr  = (paddr == adcc_pkg::SPECIAL_FUNC_OFS);
  wire hit_psr  = (paddr == adcc_pkg::PROC_STATUS_OFS);
  wire mapped   = hit_mux | hit_csr | hit_lo | hit_hi | hit_sfr | hit_psr;
  wire wr_mux   = wr_en & hit_mux;
  wire wr_csr   = wr_en & hit_csr;
  wire wr_sfr   = wr_en & hit_sfr;
  wire wr_psr   = wr_en & hit_psr;
  wire rd_lo    = rd_en & hit_lo;
  wire rd_hi    = rd_en & hit_hi;

  wire w_enable = pwdata[adcc_pkg::ENABLE_BIT];
  wire w_start  = pwdata[adcc_pkg::START_BIT];
  wire w_flag   = pwdata[adcc_pkg::DONE_FLAG_BIT];

  // ----------------------------------------------------------------------
  // Prescaler: toggles converter clock every half division
  // ----------------------------------------------------------------------
  wire [6:0] half_div = (prescale_q == 3'h0) ? 7'd0 :
                        7'((8'd1 << prescale_q) >> 1) - 7'd1;      // [R18]
  wire       presc_wrap = (presc_cnt_q >= half_div);
  wire       conv_tick  = presc_wrap & conv_clk_q;   // Falling half ends cycle

  // ----------------------------------------------------------------------
  // Trigger edge detect; middle and last stages must agree
  // ----------------------------------------------------------------------
  wire [TRIG_SOURCES-1:0] trig_agree = ~(trig_s2_q ^ trig_s3_q);
  wire [TRIG_SOURCES-1:0] trig_next  =
    (trig_agree & trig_s3_q) | (~trig_agree & trig_stable_q);
  wire [2:0] trig_idx   = trig_sel_q - 3'h1;
  wire       trig_level = (trig_sel_q == adcc_pkg::TRIG_FREE_RUN) ? 1'b0 :
                          trig_stable_q[trig_idx];                  // [R21]
  wire       trig_rise  = trig_level & ~trig_prev_q;

  // ----------------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------------
  wire busy       = (state_q == adcc_pkg::ADCC_CONVERT);
  wire sw_start   = wr_csr & w_start & w_enable;                   // [R10]
  wire free_run   = auto_trig_q &
                    (trig_sel_q == adcc_pkg::TRIG_FREE_RUN);
  wire auto_start = enable_q & auto_trig_q & trig_rise;            // [R13]
  wire abort      = wr_csr & ~w_enable;                            // [R9]
  wire conv_len_done = conv_tick &
    (cycle_cnt_q == ((first_q ? adcc_pkg::FIRST_CONV_CYCLES :
                      adcc_pkg::NORMAL_CONV_CYCLES) - 5'd1));       // [R11]
  wire complete   = busy & conv_len_done & ~abort;
  wire start_req  = sw_start | auto_start | (complete & free_run);
  // Divider restarts so a conversion spans only whole converter cycles
  wire start_now  = ~busy & start_req;                             // [R11]
  wire result_frozen = low_read_q & ~rd_hi;                        // [R20]

  // ----------------------------------------------------------------------
  // Result presentation
  // ----------------------------------------------------------------------
  wire       left_align = input_select_q[adcc_pkg::LEFT_ALIGN_BIT];
  wire [7:0] low_view   = left_align ? {result_q[1:0], 6'h00} :
                                       result_q[7:0];               // [R19]
  wire [7:0] high_view  = left_align ? result_q[9:2] :
                                       {6'h00, result_q[9:8]};      // [R3]
  wire [7:0] csr_view   = {enable_q, busy, auto_trig_q, done_flag_q,
                           irq_en_q, prescale_q};                   // [R12]
  wire [7:0] rd_byte    =
    hit_mux ? input_select_q :
    hit_csr ? csr_view :
    hit_lo  ? low_view :
    hit_hi  ? high_view :
    hit_sfr ? {trig_sel_q, 5'h00} :
    hit_psr ? {global_ie_q, 7'h00} : 8'h00;                        // [R4]

  // ----------------------------------------------------------------------
  // APB answer: no wait state, answer in first access cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= rd_en ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_q <= adcc_pkg::INPUT_SELECT_RST;
      {enable_q, auto_trig_q, irq_en_q, prescale_q} <= 6'h00;
      trig_sel_q     <= adcc_pkg::SPECIAL_FUNC_RST[7:5];
      global_ie_q    <= 1'b0;
    end else begin
      if (wr_mux)
        input_select_q <= pwdata[7:0];
      if (wr_csr) begin
        enable_q    <= w_enable;                                   // [R9]
        auto_trig_q <= pwdata[adcc_pkg::AUTO_TRIG_BIT];
        irq_en_q    <= pwdata[adcc_pkg::IRQ_EN_BIT];
        prescale_q  <= pwdata[adcc_pkg::PRESCALE_MSB:0];
      end
      if (wr_sfr)
        trig_sel_q <= pwdata[adcc_pkg::TRIG_SEL_MSB:adcc_pkg::TRIG_SEL_LSB];
      if (wr_psr)
        global_ie_q <= pwdata[adcc_pkg::GLOBAL_IE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Completion flag: a new completion wins over a clear
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      done_flag_q <= 1'b0;
    else if (complete)
      done_flag_q <= 1'b1;                                         // [R14]
    else if ((wr_csr & w_flag) | completion_irq_ack)
      done_flag_q <= 1'b0;                                         // [R16]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= (done_flag_q | complete) & irq_en_q & global_ie_q &
               ~((wr_csr & w_flag) | completion_irq_ack) |
               complete & irq_en_q & global_ie_q;                 // [R15]
  end

  // ----------------------------------------------------------------------
  // Converter clock divider
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_q <= 7'd0;
      conv_clk_q  <= 1'b0;
    end else if (!enable_q || start_now) begin                     // [R11]
      presc_cnt_q <= 7'd0;
      conv_clk_q  <= 1'b0;
    end else if (presc_wrap) begin
      presc_cnt_q <= 7'd0;
      conv_clk_q  <= ~conv_clk_q;
    end else begin
      presc_cnt_q <= presc_cnt_q + 7'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_q     <= '0;
      trig_s2_q     <= '0;
      trig_s3_q     <= '0;
      trig_stable_q <= '0;
      trig_prev_q   <= 1'b0;
    end else begin
      trig_s1_q     <= trigger_flags;
      trig_s2_q     <= trig_s1_q;
      trig_s3_q     <= trig_s2_q;
      trig_stable_q <= trig_next;
      trig_prev_q   <= trig_level;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer; starts align to a converter clock boundary
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= adcc_pkg::ADCC_IDLE;
      cycle_cnt_q <= 5'd0;
      first_q     <= 1'b1;
      ref_lat_q   <= 2'h0;
      chan_lat_q  <= 5'h00;
    end else if (abort || !enable_q) begin
      // Enable and start in one write: divider is held, so start at once
      state_q     <= sw_start ? adcc_pkg::ADCC_CONVERT :
                                adcc_pkg::ADCC_IDLE;               // [R9]
      cycle_cnt_q <= 5'd0;
      first_q     <= 1'b1;                                         // [R11]
      if (sw_start) begin
        ref_lat_q  <= input_select_q[7:6];                         // [R1]
        chan_lat_q <= input_select_q[4:0];                         // [R22]
      end
    end else begin
      unique case (state_q)
        adcc_pkg::ADCC_IDLE: begin
          if (start_req) begin
            state_q     <= adcc_pkg::ADCC_CONVERT;
            cycle_cnt_q <= 5'd0;
            ref_lat_q   <= input_select_q[7:6];                    // [R1]
            chan_lat_q  <= input_select_q[4:0];                    // [R22]
          end
        end
        adcc_pkg::ADCC_CONVERT: begin
          if (conv_len_done) begin
            first_q     <= 1'b0;
            cycle_cnt_q <= 5'd0;
            ref_lat_q   <= input_select_q[7:6];                    // [R2]
            chan_lat_q  <= input_select_q[4:0];                    // [R2]
            if (!free_run)
              state_q <= adcc_pkg::ADCC_IDLE;
          end else if (conv_tick) begin
            cycle_cnt_q <= cycle_cnt_q + 5'd1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Result register and read lock
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q   <= 10'h000;
      low_read_q <= 1'b0;
    end else begin
      if (complete && !result_frozen)
        result_q <= analog_result;                                 // [R14]
      if (rd_hi)
        low_read_q <= 1'b0;
      else if (rd_lo)
        low_read_q <= 1'b1;                                        // [R20]
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  logic sample_q;
  logic power_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= 1'b0;
      power_q  <= 1'b0;
    end else begin
      sample_q <= busy & (cycle_cnt_q < 5'd2);
      power_q  <= enable_q;                                        // [R9]
    end
  end

  // Channel/gain decode (R5-R8) lives in the analog core from these codes
  assign reference_select    = ref_lat_q;                          // [R1]
  assign channel_gain_select = chan_lat_q;            // [R5] [R6] [R7] [R8]
  assign converter_power     = power_q;
  assign sample_hold         = sample_q;
  assign converter_clock     = conv_clk_q;
  assign completion_irq      = irq_q;
  assign pready              = pready_q;
  assign prdata              = prdata_q;
  assign pslverr             = pslverr_q;

endmodule

// ---- verif/adcc_core_model.sv ----
// Stand-in for the analog core: latches the selection, returns a code
`timescale 1ns/100ps

module adcc_core_model (
  // Core control
  input  wire logic       converter_power,
  input  wire logic       sample_hold,
  input  wire logic [1:0] reference_select,
  input  wire logic [4:0] channel_gain_select,
  // Core result
  output logic      [9:0] analog_result
);
  logic [9:0] held_q = 10'h000;

  // Result carries the sampled reference and channel, so the bench can tell
  // which selection a conversion really used
  always @(negedge sample_hold) begin
    held_q <= {reference_select, 3'b101, channel_gain_select};
  end

  // A powered-down core shows a pattern no stale result can match
  assign analog_result = converter_power ? held_q : ~held_q;
endmodule

// ---- verif/adcc_top_monitor.sv ----
// Port-level checker for the converter control block
`timescale 1ns/100ps

module adcc_top_monitor #(
  parameter int TRIG_SOURCES = 7
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Interrupt and core
  input wire logic        completion_irq_ack,
  input wire logic        completion_irq,
  input wire logic        converter_power,
  input wire logic [1:0]  reference_select,
  input wire logic [4:0]  channel_gain_select,
  input wire logic        sample_hold,
  input wire logic        converter_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ONE_WAIT: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("answer outside access phase");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("answer held past one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without answer");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  AST_SEL_HELD: assert property (sample_hold && $past(sample_hold) |->
    $stable(reference_select) && $stable(channel_gain_select))
    else $error("selection moved while sampling");
  AST_OFF_QUIET: assert property (!converter_power &&
    !$past(converter_power) |-> !sample_hold && !converter_clock)
    else $error("core active while powered off");
  AST_ACK_CLEARS: assert property (completion_irq_ack &&
    completion_irq |-> ##[1:2] !completion_irq)
    else $error("acknowledge left request high");
endmodule

bind adcc_top adcc_top_monitor #(.TRIG_SOURCES(TRIG_SOURCES))
  i_adcc_top_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .completion_irq_ack(completion_irq_ack), .completion_irq(completion_irq),
  .converter_power(converter_power), .reference_select(reference_select),
  .channel_gain_select(channel_gain_select), .sample_hold(sample_hold),
  .converter_clock(converter_clock));

// ---- verif/adc_control_registers_test.sv ----
// Self-checking bench for the converter control registers
`timescale 1ns/100ps

`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module adc_control_registers_test;
  localparam logic [7:0] A_IN = adcc_pkg::INPUT_SELECT_OFS;
  localparam logic [7:0] A_CS = adcc_pkg::CONTROL_STATUS_OFS;
  localparam logic [7:0] A_LO = adcc_pkg::RESULT_LOW_OFS;
  localparam logic [7:0] A_HI = adcc_pkg::RESULT_HIGH_OFS;
  localparam logic [7:0] A_TS = adcc_pkg::SPECIAL_FUNC_OFS;
  localparam logic [7:0] A_GI = adcc_pkg::PROC_STATUS_OFS;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  trigger_flags;
  logic        completion_irq_ack, completion_irq, converter_power;
  logic        sample_hold, converter_clock;
  logic [1:0]  reference_select;
  logic [4:0]  channel_gain_select;
  logic [9:0]  analog_result;
  int          n_fail, num_checks, cyc, t0;

  adcc_top i_adcc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trigger_flags(trigger_flags), .completion_irq_ack(completion_irq_ack),
    .completion_irq(completion_irq), .converter_power(converter_power),
    .reference_select(reference_select), .sample_hold(sample_hold),
    .channel_gain_select(channel_gain_select),
    .converter_clock(converter_clock), .analog_result(analog_result));

  adcc_core_model i_adcc_core_model (.converter_power(converter_power),
    .sample_hold(sample_hold), .reference_select(reference_select),
    .channel_gain_select(channel_gain_select),
    .analog_result(analog_result));

  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [9:0] res(logic [1:0] r, logic [4:0] c);
    return {r, 3'b101, c};
  endfunction
  function automatic logic [7:0] hi(logic [9:0] r, logic l);
    return l ? r[9:2] : {6'h00, r[9:8]};
  endfunction
  function automatic logic [7:0] lo(logic [9:0] r, logic l);
    return l ? {r[1:0], 6'h00} : r[7:0];
  endfunction

  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Called just after a rising edge; idle cycle after each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin n_fail++; end_sim(); end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    `CHK({e, q}, {1'b0, 24'h00_0000, exp})
  endtask

  task automatic go(input logic [7:0] d);
    t0 = cyc;
    wr(A_CS, d);
  endtask

  // Polls the completion flag; len in pclk cycles, 0 skips the timing check
  task automatic done(input int len);
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin apb(1'b0, A_CS, 8'h00, q, e); n++; end
    while (q[4] !== 1'b1 && n < 600);
    if (n >= 600) begin n_fail++; end_sim(); end
    if (len > 0) `CHK(cyc - t0 >= len - 2 && cyc - t0 <= len + 6, 1'b1)
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        e;
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    trigger_flags = 7'h00; completion_irq_ack = 1'b0;
    n_fail = 0; num_checks = 0; cyc = 0; t0 = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_IN, 8'h00);
    rdc(A_CS, 8'h00);
    apb(1'b0, 8'h20, 8'h00, q, e);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    wr(A_IN, 8'h45);
    go(8'hC0);
    rdc(A_CS, 8'hC0);
    done(50);
    rdc(A_CS, 8'h90);
    rdc(A_LO, lo(res(2'h1, 5'h05), 1'b0));
    rdc(A_HI, hi(res(2'h1, 5'h05), 1'b0));
    wr(A_CS, 8'h80);
    rdc(A_CS, 8'h90);
    wr(A_CS, 8'h90);
    rdc(A_CS, 8'h80);
    // Selection written mid-conversion waits for completion
    wr(A_IN, 8'hDE);
    go(8'hC3);
    wr(A_IN, 8'h27);
    `CHK({reference_select, channel_gain_select}, 7'h7E)
    rdc(A_HI, hi(res(2'h1, 5'h05), 1'b1));
    done(104);
    `CHK({reference_select, channel_gain_select}, 7'h07)
    rdc(A_LO, lo(res(2'h3, 5'h1E), 1'b1));
    go(8'hD3);
    done(104);
    // A result completing while locked is dropped, not deferred
    rdc(A_HI, hi(res(2'h3, 5'h1E), 1'b1));
    rdc(A_LO, lo(res(2'h3, 5'h1E), 1'b1));
    rdc(A_HI, hi(res(2'h3, 5'h1E), 1'b1));
    for (int k = 0; k < 8; k++) begin
      go(8'hD0 | 8'(k));
      done(13 * ((k == 0) ? 2 : (1 << k)));
    end
    rdc(A_HI, hi(res(2'h0, 5'h07), 1'b1));
    // Interrupt request, masking and acknowledge
    wr(A_GI, 8'h80);
    wr(A_CS, 8'h88);
    `CHK(completion_irq, 1'b1)
    wr(A_CS, 8'h80);
    `CHK(completion_irq, 1'b0)
    wr(A_GI, 8'h00);
    wr(A_CS, 8'h88);
    `CHK(completion_irq, 1'b0)
    wr(A_GI, 8'h80);
    `CHK(completion_irq, 1'b1)
    completion_irq_ack <= 1'b1;
    @(posedge pclk);
    completion_irq_ack <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(completion_irq, 1'b0)
    rdc(A_CS, 8'h88);
    // Abort by disabling
    go(8'hC0);
    repeat (10) @(posedge pclk);
    wr(A_CS, 8'h00);
    `CHK(converter_power, 1'b0)
    repeat (80) @(posedge pclk);
    rdc(A_CS, 8'h00);
    // Auto trigger on a rising flag, then free running
    wr(A_TS, 8'h20);
    wr(A_CS, 8'hA0);
    repeat (100) @(posedge pclk);
    rdc(A_CS, 8'hA0);
    trigger_flags <= 7'h01;
    done(0);
    trigger_flags <= 7'h00;
    wr(A_TS, 8'h00);
    go(8'hF0);
    done(26);
    wr(A_CS, 8'hB0);
    done(0);
    end_sim();
  end

  initial begin
    #(100 * 20000);
    n_fail++;
    end_sim();
  end
endmodule
